/* dpr_regs.svh */
// Register indices, field positions, reset values and timing counts of the dark pixel readout block
// =====================================================================
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH
// =====================================================================
// Register indices (byte address is four times the index)
`define DPR_IDX_READ_A 6'h21
`define DPR_IDX_SHOW 6'h22
`define DPR_IDX_FLASH 6'h23
`define DPR_IDX_IRQ_STAT 6'h30
`define DPR_IDX_IRQ_CLR 6'h31
`define DPR_IDX_IRQ_EN 6'h32
`define DPR_IDX_CTRL 6'h33
`define DPR_IDX_HB_MIN 6'h34
// =====================================================================
// Reset values
`define DPR_RST_READ_A 16'h8490
`define DPR_RST_SHOW 16'h0107
`define DPR_RST_FLASH 16'h0608
`define DPR_RST_CTRL 16'h0000
// =====================================================================
// Field positions
`define DPR_BIN 15
`define DPR_RSKIP_EN 4
`define DPR_RSKIP_LSB 2
`define DPR_NCOL 10
`define DPR_SHOW_COL 9
`define DPR_READ_COL 8
`define DPR_SHOW_ROW 7
`define DPR_RSTART_LSB 4
`define DPR_NROW_LSB 0
`define DPR_FL_PIN 15
`define DPR_FL_TRIG 14
`define DPR_FL_XEN 13
`define DPR_FL_DLY_LSB 11
`define DPR_CTX_B 0
`define DPR_IRQ_FRAME 0
`define DPR_IRQ_FLASH 1
// =====================================================================
// Counts
`define DPR_PIX_DIV 2'h2
`define DPR_DARK_ALL 12'h028
`define DPR_DARK_WIDE 12'h024
`define DPR_DARK_NARROW 12'h014
`define DPR_DARK_GAP 12'h002
`define DPR_GUARD 11'h004
`define DPR_ROW_ACT0 11'h009
`define DPR_HB_MIN_BASE 12'h010
`define DPR_XENON_UNIT_M1 10'h3FF
`endif

/* dpr_pkg.sv */
// Types shared by the dark pixel readout block
package dpr_pkg;
	typedef struct packed {
		logic valid;
		logic [5:0] idx;
		logic [31:0] data;
		logic [3:0] strb;
	} dpr_wr_t;
	typedef struct packed {
		logic valid;
		logic [5:0] idx;
	} dpr_rd_req_t;
	typedef struct packed {
		logic [31:0] rdata;
		logic rd_hit;
		logic wr_hit;
	} dpr_rd_rsp_t;
	typedef struct packed {
		logic aw_have;
		logic [5:0] aw_idx;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dpr_axil_t;
	typedef struct packed {
		logic [1:0] cnt;
		logic tick;
	} dpr_div_t;
	typedef struct packed {
		logic [15:0] read_a;
		logic [15:0] show;
		logic [15:0] flash_cfg;
		logic [15:0] ctrl;
		logic [15:0] read_sh;
		logic [15:0] show_sh;
		logic xen_sh;
		logic [11:0] col;
		logic [10:0] row;
		logic flash_on;
		logic [7:0] fl_units;
		logic [9:0] fl_sub;
		logic trig;
		logic [1:0] dly;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
		logic fv;
		logic lv;
		logic dark;
		logic dcs;
		logic [10:0] row_addr;
		logic [11:0] col_addr;
	} dpr_core_t;
endpackage : dpr_pkg

/* dpr_clkdiv.sv */
// Pixel rate enable divider
`timescale 1ns/1ps
`include "dpr_regs.svh"
module dpr_clkdiv (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	output logic tick // One-cycle pixel rate enable
);
	dpr_pkg::dpr_div_t q, n;
	always_comb begin
		n = q;
		n.tick = (q.cnt == `DPR_PIX_DIV - 2'h1);
		n.cnt = n.tick ? 2'h0 : q.cnt + 2'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
	assign tick = q.tick;
endmodule : dpr_clkdiv

/* dpr_axil.sv */
// AXI4-Lite slave front end of the register file
`timescale 1ns/1ps
module dpr_axil (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] awaddr, // Write address
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Write byte strobes
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [7:0] araddr, // Read address
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	output dpr_pkg::dpr_wr_t wr, // Register write pulse
	output dpr_pkg::dpr_rd_req_t rd, // Register read request
	input dpr_pkg::dpr_rd_rsp_t rsp // Read data and decode hits
);
	dpr_pkg::dpr_axil_t q, n;
	always_comb begin
		n = q;
		awready = !q.aw_have && !q.bvalid;
		wready = !q.w_have && !q.bvalid;
		arready = !q.rvalid;
		wr.valid = q.aw_have && q.w_have && !q.bvalid;
		wr.idx = q.aw_idx;
		wr.data = q.w_data;
		wr.strb = q.w_strb;
		rd.valid = arvalid && arready;
		rd.idx = araddr[7:2];
		if (awvalid && awready) begin
			n.aw_have = 1'b1;
			n.aw_idx = awaddr[7:2];
		end
		if (wvalid && wready) begin
			n.w_have = 1'b1;
			n.w_data = wdata;
			n.w_strb = wstrb;
		end
		if (wr.valid) begin
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = rsp.wr_hit ? 2'h0 : 2'h2;
		end
		if (q.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (rd.valid) begin
			n.rvalid = 1'b1;
			n.rdata = rsp.rdata;
			n.rresp = rsp.rd_hit ? 2'h0 : 2'h2;
		end
		if (q.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
endmodule : dpr_axil

/* dpr_top.sv */
// Dark pixel placement, row skip and xenon flash control with AXI4-Lite registers
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dpr_regs.svh"
module dpr_top #(
	parameter logic [11:0] ACTIVE_COLS = 12'h640, // Active pixels per line
	parameter logic [11:0] LINE_TOTAL = 12'h708, // Pixel times per row
	parameter logic [10:0] ACTIVE_ROWS = 11'h4B0, // Active rows per frame
	parameter logic [10:0] FRAME_ROWS = 11'h4D8 // Row times per frame
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] awaddr, // Write address
	input wire logic awvalid, // Write address valid
	output logic awready, // Write address ready
	input wire logic [31:0] wdata, // Write data
	input wire logic [3:0] wstrb, // Write byte strobes
	input wire logic wvalid, // Write data valid
	output logic wready, // Write data ready
	output logic [1:0] bresp, // Write response
	output logic bvalid, // Write response valid
	input wire logic bready, // Write response ready
	input wire logic [7:0] araddr, // Read address
	input wire logic arvalid, // Read address valid
	output logic arready, // Read address ready
	output logic [31:0] rdata, // Read data
	output logic [1:0] rresp, // Read response
	output logic rvalid, // Read data valid
	input wire logic rready, // Read data ready
	output logic pixel_rate_clock_en, // Pixel rate enable pulse
	output logic frame_valid, // Frame strobe
	output logic line_valid, // Line strobe
	output logic dark_pixel, // Current pixel is a dark pixel
	output logic dark_col_strobe, // Dark column sample for noise correction
	output logic [10:0] row_addr, // Array row address of current pixel
	output logic [11:0] col_addr, // Array column address of current pixel
	output logic flash, // Flash output pin
	output logic integ_full_frame, // Integration held at one frame
	output logic irq // Interrupt, active high level
);
	dpr_pkg::dpr_wr_t wr;
	dpr_pkg::dpr_rd_req_t rd;
	dpr_pkg::dpr_rd_rsp_t rsp;
	dpr_pkg::dpr_core_t q, n;
	logic pix_en;
	logic skip_on, binning, line_end, frame_start, vb_start, fire;
	logic in_drow, in_act, in_dcol, in_acol;
	logic [1:0] skip_code;
	logic [2:0] skip_sh;
	logic [10:0] step, act_rows, nd, drow0, act_end;
	logic [11:0] dark_cnt, dark_first, shift, hb, dcol0, lv_start, hb_min;

	// =====================================================================
	// Sub-blocks
	dpr_clkdiv u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(pix_en)
	);
	dpr_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr(wr),
		.rd(rd),
		.rsp(rsp)
	);

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// =====================================================================
	// Geometry, from the frame-start copies so one frame never mixes settings; only hb_min reads the live show word
	always_comb begin
		// Context select is folded into the shadow copy at frame start
		skip_on = q.read_sh[`DPR_RSKIP_EN];
		binning = q.read_sh[`DPR_BIN];
		skip_code = q.read_sh[`DPR_RSKIP_LSB+1:`DPR_RSKIP_LSB];
		skip_sh = skip_on ? {1'b0, skip_code} + 3'h1 : 3'h0;
		step = 11'h001 << skip_sh;
		act_rows = ACTIVE_ROWS >> skip_sh;
		if (binning) begin
			dark_cnt = `DPR_DARK_ALL;
			dark_first = 12'h000;
		end else begin
			dark_cnt = q.show_sh[`DPR_NCOL] ? `DPR_DARK_WIDE : `DPR_DARK_NARROW;
			dark_first = 12'h004;
		end
		shift = dark_cnt + `DPR_DARK_GAP;
		hb = LINE_TOTAL - ACTIVE_COLS;
		dcol0 = hb - shift;
		lv_start = q.show_sh[`DPR_SHOW_COL] ? dcol0 : hb;
		// Row time stays LINE_TOTAL; only the blanking floor moves
		hb_min = `DPR_HB_MIN_BASE + (q.show[`DPR_READ_COL] ? shift : 12'h000);
		nd = q.show_sh[`DPR_SHOW_ROW] ? {8'h00, q.show_sh[`DPR_NROW_LSB+2:`DPR_NROW_LSB]} + 11'h001 : 11'h000;
		drow0 = `DPR_ROW_ACT0 - nd;
		act_end = `DPR_ROW_ACT0 + act_rows;
	end

	// =====================================================================
	// Register read data and read/write hit decode
	always_comb begin
		rsp.rdata = 32'h0000_0000;
		rsp.rd_hit = 1'b1;
		case (rd.idx)
			`DPR_IDX_READ_A: rsp.rdata[15:0] = q.read_a;
			`DPR_IDX_SHOW: rsp.rdata[15:0] = q.show;
			`DPR_IDX_FLASH: rsp.rdata[15:0] = {q.flash_on, q.trig, q.flash_cfg[13:0]};
			`DPR_IDX_IRQ_STAT: rsp.rdata[1:0] = q.irq_stat;
			`DPR_IDX_IRQ_CLR: rsp.rdata = 32'h0000_0000;
			`DPR_IDX_IRQ_EN: rsp.rdata[1:0] = q.irq_en;
			`DPR_IDX_CTRL: rsp.rdata[15:0] = q.ctrl;
			`DPR_IDX_HB_MIN: rsp.rdata[11:0] = hb_min;
			default: rsp.rd_hit = 1'b0;
		endcase
		case (wr.idx)
			`DPR_IDX_READ_A, `DPR_IDX_SHOW, `DPR_IDX_FLASH, `DPR_IDX_IRQ_CLR, `DPR_IDX_IRQ_EN, `DPR_IDX_CTRL: begin
				rsp.wr_hit = 1'b1;
			end
			default: rsp.wr_hit = 1'b0;
		endcase
	end

	// =====================================================================
	// Next state
	always_comb begin
		n = q;
		line_end = pix_en && (q.col == LINE_TOTAL - 12'h001);
		frame_start = line_end && (q.row == FRAME_ROWS - 11'h001);
		vb_start = line_end && (q.row == act_end - 11'h001);
		fire = vb_start && q.xen_sh && (q.dly == q.flash_cfg[`DPR_FL_DLY_LSB+1:`DPR_FL_DLY_LSB])
			&& (q.flash_cfg[7:0] != 8'h00);
		in_drow = 1'b0;
		in_act = 1'b0;
		in_dcol = 1'b0;
		in_acol = 1'b0;
		// Software writes; status bits 15:14 of the flash word are read-only
		if (wr.valid) begin
			case (wr.idx)
				`DPR_IDX_READ_A: n.read_a = merge16(q.read_a, wr.data, wr.strb);
				`DPR_IDX_SHOW: n.show = merge16(q.show, wr.data, wr.strb);
				`DPR_IDX_FLASH: n.flash_cfg = merge16(q.flash_cfg, wr.data, wr.strb) & 16'h3FFF;
				`DPR_IDX_IRQ_CLR: n.irq_stat = q.irq_stat & ~wr.data[1:0];
				`DPR_IDX_IRQ_EN: n.irq_en = wr.data[1:0];
				`DPR_IDX_CTRL: n.ctrl = merge16(q.ctrl, wr.data, wr.strb) & 16'h0001;
				default: n.ctrl = q.ctrl;
			endcase
		end
		if (pix_en) begin
			n.col = line_end ? 12'h000 : q.col + 12'h001;
			if (line_end) begin
				n.row = frame_start ? 11'h000 : q.row + 11'h001;
			end
			if (frame_start) begin
				n.read_sh = q.read_a;
				// Context B has no skip or binning; latching it here keeps a mid-blank switch from reshaping the frame
				if (q.ctrl[`DPR_CTX_B]) begin
					n.read_sh[`DPR_BIN] = 1'b0;
					n.read_sh[`DPR_RSKIP_EN] = 1'b0;
				end
				n.show_sh = q.show;
				n.xen_sh = q.flash_cfg[`DPR_FL_XEN];
				if (!q.flash_cfg[`DPR_FL_XEN]) begin
					n.dly = 2'h0;
				end else if (q.xen_sh && q.dly != 2'h3) begin
					n.dly = q.dly + 2'h1;
				end
			end
			in_drow = (n.row >= drow0) && (n.row < `DPR_ROW_ACT0);
			in_act = (n.row >= `DPR_ROW_ACT0) && (n.row < act_end);
			in_dcol = (n.col >= dcol0) && (n.col < hb - `DPR_DARK_GAP);
			in_acol = n.col >= hb;
			n.fv = in_drow || in_act;
			n.lv = n.fv && (n.col >= lv_start);
			n.dark = in_drow || (in_act && in_dcol && q.show_sh[`DPR_SHOW_COL]);
			n.dcs = in_act && in_dcol && (q.show_sh[`DPR_READ_COL] || q.show_sh[`DPR_SHOW_COL]);
			if (in_drow) begin
				n.row_addr = `DPR_GUARD + {8'h00, q.show_sh[`DPR_RSTART_LSB+2:`DPR_RSTART_LSB]} + (n.row - drow0);
			end else if (in_act) begin
				n.row_addr = (n.row - `DPR_ROW_ACT0) << skip_sh;
			end else begin
				n.row_addr = 11'h000;
			end
			if (in_dcol && !in_acol) begin
				n.col_addr = dark_first + (n.col - dcol0);
			end else if (in_acol) begin
				n.col_addr = n.col - hb;
			end else begin
				n.col_addr = 12'h000;
			end
			// Xenon pulse, counted in units of 1024 pixel times
			if (fire) begin
				n.flash_on = 1'b1;
				n.fl_units = q.flash_cfg[7:0];
				n.fl_sub = 10'h000;
			end else if (q.flash_on) begin
				n.fl_sub = q.fl_sub + 10'h001;
				if (q.fl_sub == `DPR_XENON_UNIT_M1) begin
					n.fl_units = q.fl_units - 8'h01;
					if (q.fl_units == 8'h01) begin
						n.flash_on = 1'b0;
					end
				end
			end
			// Readout starting ends the pulse, so it never overlaps rows
			if (n.fv) begin
				n.flash_on = 1'b0;
			end
		end
		if (frame_start) begin
			n.trig = 1'b0;
			n.irq_stat[`DPR_IRQ_FRAME] = 1'b1;
		end
		// Set wins over the frame-start clear and the software clear
		if (n.flash_on) begin
			n.trig = 1'b1;
		end
		if (n.flash_on && !q.flash_on) begin
			n.irq_stat[`DPR_IRQ_FLASH] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.read_a <= `DPR_RST_READ_A;
			q.show <= `DPR_RST_SHOW;
			q.flash_cfg <= `DPR_RST_FLASH;
			q.ctrl <= `DPR_RST_CTRL;
			q.read_sh <= `DPR_RST_READ_A;
			q.show_sh <= `DPR_RST_SHOW;
		end else begin
			q <= n;
		end
	end

	// =====================================================================
	// Outputs
	assign pixel_rate_clock_en = pix_en;
	assign frame_valid = q.fv;
	assign line_valid = q.lv;
	assign dark_pixel = q.dark;
	assign dark_col_strobe = q.dcs;
	assign row_addr = q.row_addr;
	assign col_addr = q.col_addr;
	assign flash = q.flash_on;
	assign integ_full_frame = q.xen_sh;
	assign irq = |(q.irq_stat & q.irq_en);

	// =====================================================================
	// Checks
	default clocking chk_clk @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_flash_rise;
		!q.flash_on ##1 q.flash_on;
	endsequence
	sequence s_flash_fall;
		q.flash_on ##1 !q.flash_on;
	endsequence

	a_flash_readback: assert property (@(posedge aclk) disable iff (!aresetn)
		rd.valid && rd.idx == `DPR_IDX_FLASH |-> rsp.rdata[15] == flash)
		else $error("flash status bit differs from flash pin");
	a_trig_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		flash |-> q.trig && (!(rd.valid && rd.idx == `DPR_IDX_FLASH) || rsp.rdata[15:14] == 2'h3))
		else $error("triggered bit clear while flash high");
	a_flash_blank: assert property (@(posedge aclk) disable iff (!aresetn)
		s_flash_rise |-> q.xen_sh && !frame_valid)
		else $error("flash started outside xenon blanking");
	a_flash_no_readout: assert property (@(posedge aclk) disable iff (!aresetn)
		flash |-> !frame_valid && integ_full_frame)
		else $error("flash overlaps readout");
	a_flash_end: assert property (@(posedge aclk) disable iff (!aresetn)
		s_flash_fall |-> frame_valid || ($past(q.fl_units) == 8'h01 && $past(q.fl_sub) == `DPR_XENON_UNIT_M1))
		else $error("flash pulse ended early");
	a_lv_start: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(line_valid) |-> q.col == lv_start)
		else $error("line strobe rose at wrong pixel");
	a_dark_row_addr: assert property (@(posedge aclk) disable iff (!aresetn)
		frame_valid && q.row < `DPR_ROW_ACT0 |-> dark_pixel && row_addr == `DPR_GUARD
			+ {8'h00, q.show_sh[`DPR_RSTART_LSB+2:`DPR_RSTART_LSB]} + (q.row - drow0))
		else $error("dark row address wrong");
	a_skip_step: assert property (@(posedge aclk) disable iff (!aresetn)
		frame_valid && q.row > `DPR_ROW_ACT0 && $changed(q.row) |-> row_addr == $past(row_addr) + step)
		else $error("row skip step wrong");
	a_shadow_frame: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(q.show_sh) |-> q.row == 11'h000 && q.col == 12'h000)
		else $error("dark placement changed mid frame");
	a_dark_rows_first: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(frame_valid) |-> q.row == drow0)
		else $error("frame strobe rose at wrong row");
	// Dark columns are checked against the counts, not the placement counters
	a_dark_col_range: assert property (
		dark_col_strobe |-> (binning ? col_addr < `DPR_DARK_ALL
			: col_addr >= 12'h004 && col_addr < 12'h004 + (q.show_sh[`DPR_NCOL] ? `DPR_DARK_WIDE : `DPR_DARK_NARROW)))
		else $error("dark column address out of range");
	a_dcs_window: assert property (
		dark_col_strobe |-> frame_valid && q.row >= `DPR_ROW_ACT0 && q.col < hb - `DPR_DARK_GAP)
		else $error("correction sample outside dark columns");
	a_gap_idle: assert property (
		q.row >= `DPR_ROW_ACT0 && q.col >= hb - `DPR_DARK_GAP && q.col < hb |-> !dark_pixel && !dark_col_strobe)
		else $error("idle gap carries a dark pixel");
	// Skipped rows must land on multiples of the skip step
	a_skip_align: assert property (
		frame_valid && q.row >= `DPR_ROW_ACT0 |-> (row_addr & (step - 11'h001)) == 11'h000)
		else $error("row address off the skip grid");
	a_fv_end: assert property (
		$fell(frame_valid) |-> q.row == act_end)
		else $error("frame strobe fell at wrong row");
	a_pulse_start: assert property (
		$rose(flash) |-> q.fl_sub == 10'h000 && q.fl_units == q.flash_cfg[7:0])
		else $error("flash pulse loaded wrong length");
	a_delay_gate: assert property (
		$rose(flash) |-> q.dly == q.flash_cfg[`DPR_FL_DLY_LSB+1:`DPR_FL_DLY_LSB])
		else $error("flash fired in wrong frame");
	// With no pulse standing one cycle after the frame edge, the triggered bit must be clear
	sequence s_frame_turn;
		frame_start ##1 !flash;
	endsequence
	a_trig_clear: assert property (
		s_frame_turn |-> !q.trig)
		else $error("triggered bit kept past frame start");
	a_lv_in_frame: assert property (
		line_valid |-> frame_valid)
		else $error("line strobe outside frame");
endmodule : dpr_top

/* dpr_host_model.sv */
// Host side pixel stream receiver that measures line, frame and flash timing
`timescale 1ns/1ps
module dpr_host_model (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic tick, // Pixel rate enable
	input wire logic fv, // Frame strobe
	input wire logic lv, // Line strobe
	input wire logic dark, // Dark pixel marker
	input wire logic strobe, // Dark column correction sample
	input wire logic [10:0] row, // Row address of current pixel
	input wire logic flash, // Flash pin
	output logic [11:0] lv_len, // Pixel times of the last line
	output logic [11:0] dark_cnt, // Dark pixels inside the last line
	output logic [11:0] strobe_cnt, // Correction samples in the last row
	output logic [10:0] fv_rows, // Lines in the last frame
	output logic [10:0] first_row, // Row address of the first line of a frame
	output logic [15:0] flash_len, // Pixel times of the last flash pulse
	output logic [7:0] n_fall, // Frame ends seen
	output logic [7:0] n_rise // Frame starts seen
);
	logic p_lv, p_fv, p_fl;
	logic [11:0] c_lv, c_dk, c_st;
	logic [10:0] c_rows;
	logic [15:0] c_fl;
	// =====================================================================
	// Measurement
	// Sampled only on pixel ticks, as a real receiver would latch pixels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{p_lv, p_fv, p_fl, c_lv, c_dk, c_st, c_rows, c_fl} <= '0;
			{lv_len, dark_cnt, strobe_cnt, fv_rows, first_row, flash_len, n_fall, n_rise} <= '0;
		end else if (tick) begin
			{p_lv, p_fv, p_fl} <= {lv, fv, flash};
			c_lv <= lv ? c_lv + 12'h001 : 12'h000;
			c_dk <= lv ? c_dk + {11'h000, dark} : 12'h000;
			// Row window runs fall to fall so unshown dark columns still count
			c_st <= (!lv && p_lv) ? {11'h000, strobe} : c_st + {11'h000, strobe};
			if (!lv && p_lv) begin
				lv_len <= c_lv;
				dark_cnt <= c_dk;
				strobe_cnt <= c_st;
			end
			if (fv && !p_fv) begin
				c_rows <= 11'h000;
				n_rise <= n_rise + 8'h01;
			end else if (lv && !p_lv) begin
				c_rows <= c_rows + 11'h001;
			end
			if (lv && !p_lv && c_rows == 11'h000) begin
				first_row <= row;
			end
			if (!fv && p_fv) begin
				fv_rows <= c_rows;
				n_fall <= n_fall + 8'h01;
			end
			c_fl <= flash ? c_fl + 16'h0001 : 16'h0000;
			if (!flash && p_fl) begin
				flash_len <= c_fl;
			end
		end
	end
endmodule : dpr_host_model

/* dark_pixel_readout_and_flash_ctrl_tb.sv */
// Self-checking bench for the dark pixel readout and flash control block
`timescale 1ns/1ps
module dark_pixel_readout_and_flash_ctrl_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, s_rise, d0;
	logic [31:0] wdata, rdata, rd_val;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, tick, fv, lv, dark, strobe, flash, integ, irq;
	logic [10:0] row, fv_rows, first_row;
	logic [11:0] lv_len, dark_cnt, strobe_cnt;
	logic [15:0] flash_len;
	logic [7:0] n_fall, n_rise;
	int n_mismatch, check_count;
	// =====================================================================
	// Design and receiver
	dpr_top #(.ACTIVE_COLS(12'h030), .LINE_TOTAL(12'h064), .ACTIVE_ROWS(11'h010), .FRAME_ROWS(11'h01E)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .pixel_rate_clock_en(tick), .frame_valid(fv),
		.line_valid(lv), .dark_pixel(dark), .dark_col_strobe(strobe), .row_addr(row), .col_addr(),
		.flash(flash), .integ_full_frame(integ), .irq(irq));
	dpr_host_model host_u (.aclk(aclk), .aresetn(aresetn), .tick(tick), .fv(fv), .lv(lv), .dark(dark),
		.strobe(strobe), .row(row), .flash(flash), .lv_len(lv_len), .dark_cnt(dark_cnt),
		.strobe_cnt(strobe_cnt), .fv_rows(fv_rows), .first_row(first_row), .flash_len(flash_len),
		.n_fall(n_fall), .n_rise(n_rise));
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// =====================================================================
	// Tasks
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic hang(input string what);
		$display("timeout waiting for %s", what);
		n_mismatch++;
		end_sim();
	endtask : hang
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (aw_ok && w_ok && bvalid === 1'b1) break;
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		if (n == 200) hang("write response");
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
		int n;
		logic ar_ok;
		ar_ok = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge aclk);
			if (ar_ok && rvalid === 1'b1) break;
			if (!ar_ok && arready === 1'b1) begin
				ar_ok = 1'b1;
				arvalid <= 1'b0;
			end
		end
		if (n == 200) hang("read data");
		rd_val = rdata;
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk(what, exp, rd_val);
		@(posedge aclk);
	endtask : axi_rd
	task automatic wait_fall;
		int n;
		logic [7:0] s;
		s = n_fall;
		for (n = 0; n < 20000 && n_fall === s; n++) begin
			@(posedge aclk);
		end
		if (n_fall === s) hang("frame end");
	endtask : wait_fall
	task automatic wait_flash(input logic lvl);
		int n;
		for (n = 0; n < 30000 && flash !== lvl; n++) begin
			@(posedge aclk);
		end
		if (flash !== lvl) hang("flash");
	endtask : wait_flash
	// Writes land in vertical blanking so the next frame start picks them up whole
	task automatic run_cfg(input logic [31:0] ra, sh, ct, rows, lvl, dk, st, hb);
		axi_wr(8'h84, ra, 2'h0);
		axi_wr(8'h88, sh, 2'h0);
		axi_wr(8'hCC, ct, 2'h0);
		wait_fall();
		chk("frame rows", rows, {21'h0, fv_rows});
		chk("line length", lvl, {20'h0, lv_len});
		chk("dark columns shown", dk, {20'h0, dark_cnt});
		chk("correction samples", st, {20'h0, strobe_cnt});
		if (sh[7]) chk("first dark row", 32'h6, {21'h0, first_row});
		axi_rd(8'hD0, hb, 2'h0, "min hblank");
		$display("test config %0h %0h %0h done", ra, sh, ct);
	endtask : run_cfg
	// =====================================================================
	// Main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		n_mismatch = 0;
		check_count = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(8'h84, 32'h8490, 2'h0, "read_config_context_a");
		axi_rd(8'h88, 32'h0107, 2'h0, "dark_pixel_show_control");
		axi_rd(8'h8C, 32'h0608, 2'h0, "flash_control");
		axi_rd(8'hCC, 32'h0, 2'h0, "ctrl");
		axi_rd(8'hC8, 32'h0, 2'h0, "irq enable");
		axi_rd(8'hD0, 32'h3A, 2'h0, "min hblank");
		axi_wr(8'hFC, 32'h1234, 2'h2);
		axi_rd(8'hFC, 32'h0, 2'h2, "unmapped");
		$display("test reset values done");
		wait_fall();
		run_cfg(32'h8490, 32'h0307, 32'h0, 32'h8, 32'h5A, 32'h28, 32'h28, 32'h3A);
		run_cfg(32'h0494, 32'h0307, 32'h0, 32'h4, 32'h46, 32'h14, 32'h14, 32'h26);
		run_cfg(32'h0498, 32'h0507, 32'h0, 32'h2, 32'h30, 32'h0, 32'h24, 32'h36);
		run_cfg(32'h049C, 32'h00A2, 32'h0, 32'h4, 32'h30, 32'h0, 32'h0, 32'h10);
		run_cfg(32'h049C, 32'h00A2, 32'h1, 32'h13, 32'h30, 32'h0, 32'h0, 32'h10);
		axi_wr(8'hC8, 32'h2, 2'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		s_rise = n_rise;
		axi_wr(8'h8C, 32'h2001, 2'h0);
		wait_flash(1'b1);
		d0 = n_rise - s_rise;
		chk("frame strobe at flash", 32'h0, {31'h0, fv});
		chk("full frame integration", 32'h1, {31'h0, integ});
		chk("irq on flash", 32'h1, {31'h0, irq});
		axi_rd(8'h8C, 32'hE001, 2'h0, "flash_control live");
		wait_flash(1'b0);
		repeat (4) @(posedge aclk);
		chk("flash length", 32'h400, {16'h0, flash_len});
		axi_rd(8'hC0, 32'h3, 2'h0, "irq status");
		axi_wr(8'hC4, 32'h3, 2'h0);
		axi_rd(8'hC0, 32'h0, 2'h0, "irq status cleared");
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test xenon pulse done");
		axi_wr(8'h8C, 32'h0001, 2'h0);
		wait_fall();
		wait_fall();
		s_rise = n_rise;
		axi_wr(8'h8C, 32'h2801, 2'h0);
		wait_flash(1'b1);
		chk("flash frame delay", {24'h0, d0 + 8'h01}, {24'h0, n_rise - s_rise});
		$display("test frame delay done");
		end_sim();
	end
endmodule : dark_pixel_readout_and_flash_ctrl_tb
